// >>> shared/bram_pkg.sv
`default_nettype none
package bram_pkg;
    // Storage geometry of one block, fixed whatever arrangement is chosen
    localparam int TOTAL_BITS = 4096;
    localparam int WORD_BITS = 16;
    localparam int WORD_COUNT = 256;
    localparam int WORD_INDEX_BITS = 8;
    localparam int LOCATION_BITS = 12;
    localparam int OFFSET_BITS = 4;

    // Supported data widths, one per arrangement
    localparam int WIDTH_WIDE = 16;
    localparam int WIDTH_BYTE = 8;
    localparam int WIDTH_NIBBLE = 4;
    localparam int WIDTH_PAIR = 2;

    // Synchroniser depth for every pin that enters the clock domain
    localparam int SYNC_STAGES = 2;

    // Reset values of the control flip-flops, and the blank preload image
    localparam logic RESET_BIT = 1'b0;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] MASK_NONE = 16'h0000;
    localparam logic [TOTAL_BITS-1:0] INIT_BLANK = '0;
endpackage : bram_pkg
`default_nettype wire

// >>> rtl/bram_array.sv
`timescale 1ns/1ps
`default_nettype none

// Flip-flop store of 256 words of 16 bits with per-bit write enables
module bram_array #(
    parameter int DATA_WIDTH = bram_pkg::WIDTH_WIDE,
    parameter logic [bram_pkg::TOTAL_BITS-1:0] INIT_IMAGE = bram_pkg::INIT_BLANK
) (
    input wire logic clock,
    input wire logic writeGo,
    input wire logic [bram_pkg::WORD_INDEX_BITS-1:0] writeIndex,
    input wire logic [bram_pkg::WORD_BITS-1:0] writeWord,
    input wire logic [bram_pkg::WORD_BITS-1:0] writeBitEnable,
    input wire logic [bram_pkg::WORD_INDEX_BITS-1:0] readIndex,
    output logic [bram_pkg::WORD_BITS-1:0] readWord
);
    // Contents carry no reset, as in a real block RAM
    logic [bram_pkg::WORD_BITS-1:0] mem [bram_pkg::WORD_COUNT];

    // Configuration-time preload; location zero keeps no defined value
    initial begin
        for (int b = DATA_WIDTH; b < bram_pkg::TOTAL_BITS; b++) begin
            mem[b / bram_pkg::WORD_BITS][b % bram_pkg::WORD_BITS] = INIT_IMAGE[b];
        end
    end

    // New word merged bit by bit with the stored one, one generate lane per bit
    logic [bram_pkg::WORD_BITS-1:0] mergedWord;
    for (genvar i = 0; i < bram_pkg::WORD_BITS; i++) begin : gBit
        assign mergedWord[i] = writeBitEnable[i] ? writeWord[i] : mem[writeIndex][i];
    end

    // Single writer of the store; plain always since the preload also writes it
    always @(posedge clock) begin
        if (writeGo) begin
            mem[writeIndex] <= mergedWord;
        end
    end

    // Asynchronous look-up; the top registers the result
    assign readWord = mem[readIndex];
endmodule : bram_array

`default_nettype wire

// >>> rtl/bram_top.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Block always holds exactly 4096 bits.
// - Arrangements 256x16, 512x8, 1024x4, 2048x2.
// - Separate write and read ports.
// - Mask bit 0 writes, 1 keeps; wide only.
// - Wide arrangement addresses select one of 256.
// - Write clock rising by default, falling optional.
// - Read clock edge chosen independently.
// - Data and addresses registered on active edge.
// - Write needs enable and clock gate.
// - Read needs enable and clock gate.
// - Optional preload of contents at configuration.
// - Location zero gets no preload value.
module bram_top #(
    parameter int DATA_WIDTH = bram_pkg::WIDTH_WIDE,
    parameter int ADDR_WIDTH = $clog2(bram_pkg::TOTAL_BITS / DATA_WIDTH),
    parameter bit WRITE_FALLING_EDGE = 1'b0,
    parameter bit READ_FALLING_EDGE = 1'b0,
    parameter logic [bram_pkg::TOTAL_BITS-1:0] INIT_IMAGE = bram_pkg::INIT_BLANK
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic input_port_clock,
    input wire logic input_port_enable,
    input wire logic input_clock_gate,
    input wire logic [ADDR_WIDTH-1:0] input_port_location,
    input wire logic [DATA_WIDTH-1:0] input_port_word,
    input wire logic [bram_pkg::WORD_BITS-1:0] input_port_mask,
    input wire logic output_port_clock,
    input wire logic output_port_enable,
    input wire logic output_clock_gate,
    input wire logic [ADDR_WIDTH-1:0] output_port_location,
    output logic [DATA_WIDTH-1:0] output_port_word
);
    // Locations packed per 16-bit storage word
    localparam int LANES = bram_pkg::WORD_BITS / DATA_WIDTH;
    // Address bits that pick a lane inside a storage word
    localparam int LANE_BITS = $clog2(LANES);
    // Bits of the write pin group: clock, enable, gate, address, data, mask
    localparam int WR_BITS = 3 + ADDR_WIDTH + DATA_WIDTH + bram_pkg::WORD_BITS;
    // Bits of the read pin group: clock, enable, gate, address
    localparam int RD_BITS = 3 + ADDR_WIDTH;

    // Any arrangement must fill the block exactly
    // Stops elaboration rather than building a block of the wrong size
    if (DATA_WIDTH * (1 << ADDR_WIDTH) != bram_pkg::TOTAL_BITS) begin : gBadShape
        $error("Arrangement does not fill the block exactly");
    end
    if (DATA_WIDTH != bram_pkg::WIDTH_WIDE && DATA_WIDTH != bram_pkg::WIDTH_BYTE
        && DATA_WIDTH != bram_pkg::WIDTH_NIBBLE
        && DATA_WIDTH != bram_pkg::WIDTH_PAIR) begin : gBadWidth
        $error("Data width is not one of the supported arrangements");
    end

    // Pins grouped so the whole port moves through the same stages
    logic [WR_BITS-1:0] wrPins;
    // Read pins grouped the same way
    logic [RD_BITS-1:0] rdPins;
    // First synchroniser stages, read only by the second stages
    logic [WR_BITS-1:0] wrMeta_r;
    logic [RD_BITS-1:0] rdMeta_r;
    // Second stages, safe for logic
    logic [WR_BITS-1:0] wrSync_r;
    logic [RD_BITS-1:0] rdSync_r;
    // Previous level of each port clock, for edge detection
    logic wrClkPrev_r;
    logic rdClkPrev_r;

    assign wrPins = {input_port_clock, input_port_enable, input_clock_gate,
                     input_port_location, input_port_word, input_port_mask};
    assign rdPins = {output_port_clock, output_port_enable, output_clock_gate,
                     output_port_location};

    // Two-stage synchronisers on both pin groups
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrMeta_r <= '0;
            wrSync_r <= '0;
            rdMeta_r <= '0;
            rdSync_r <= '0;
        end else begin
            wrMeta_r <= wrPins;
            wrSync_r <= wrMeta_r;
            rdMeta_r <= rdPins;
            rdSync_r <= rdMeta_r;
        end
    end

    // Unpacked views of the synchronised write group
    logic wrClk;
    logic wrEnable;
    logic wrGate;
    logic [ADDR_WIDTH-1:0] wrLoc;
    logic [DATA_WIDTH-1:0] wrData;
    logic [bram_pkg::WORD_BITS-1:0] wrMask;
    assign {wrClk, wrEnable, wrGate, wrLoc, wrData, wrMask} = wrSync_r;

    // Unpacked views of the synchronised read group
    logic rdClk;
    logic rdEnable;
    logic rdGate;
    logic [ADDR_WIDTH-1:0] rdLoc;
    assign {rdClk, rdEnable, rdGate, rdLoc} = rdSync_r;

    // Edge detection; polarity fixed at build time per port
    logic wrRise;
    logic wrFall;
    logic wrEdge;
    logic rdRise;
    logic rdFall;
    logic rdEdge;
    assign wrRise = wrClk && !wrClkPrev_r;
    assign wrFall = !wrClk && wrClkPrev_r;
    assign wrEdge = WRITE_FALLING_EDGE ? wrFall : wrRise;
    assign rdRise = rdClk && !rdClkPrev_r;
    assign rdFall = !rdClk && rdClkPrev_r;
    assign rdEdge = READ_FALLING_EDGE ? rdFall : rdRise;

    // A request needs enable and gate together, both high
    logic wrFire;
    logic rdFire;
    assign wrFire = wrEdge && wrEnable && wrGate;
    assign rdFire = rdEdge && rdEnable && rdGate;

    // Input registers at the array boundary
    logic wrGo_r;
    logic [ADDR_WIDTH-1:0] wrLoc_r;
    logic [DATA_WIDTH-1:0] wrData_r;
    logic [bram_pkg::WORD_BITS-1:0] wrMask_r;
    logic rdGo_r;
    logic [ADDR_WIDTH-1:0] rdLoc_r;

    // Remember clock levels every cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrClkPrev_r <= bram_pkg::RESET_BIT;
            rdClkPrev_r <= bram_pkg::RESET_BIT;
        end else begin
            wrClkPrev_r <= wrClk;
            rdClkPrev_r <= rdClk;
        end
    end

    // Capture write data, address and mask on the active edge only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrGo_r <= bram_pkg::RESET_BIT;
            wrLoc_r <= '0;
            wrData_r <= '0;
            wrMask_r <= bram_pkg::MASK_NONE;
        end else begin
            wrGo_r <= wrFire;
            if (wrEdge) begin
                wrLoc_r <= wrLoc;
                wrData_r <= wrData;
                wrMask_r <= wrMask;
            end
        end
    end

    // Capture read address on the active read edge
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdGo_r <= bram_pkg::RESET_BIT;
            rdLoc_r <= '0;
        end else begin
            rdGo_r <= rdFire;
            if (rdEdge) begin
                rdLoc_r <= rdLoc;
            end
        end
    end

    // Location split: upper bits pick the storage word, lower bits the lane
    logic [bram_pkg::LOCATION_BITS-1:0] wrLocFull;
    logic [bram_pkg::LOCATION_BITS-1:0] rdLocFull;
    logic [bram_pkg::WORD_INDEX_BITS-1:0] wrIndex;
    logic [bram_pkg::WORD_INDEX_BITS-1:0] rdIndex;
    logic [bram_pkg::OFFSET_BITS-1:0] wrOffset;
    logic [bram_pkg::OFFSET_BITS-1:0] rdOffset;
    assign wrLocFull = bram_pkg::LOCATION_BITS'(wrLoc_r);
    assign rdLocFull = bram_pkg::LOCATION_BITS'(rdLoc_r);
    // In the wide arrangement the whole address is the word index
    assign wrIndex = bram_pkg::WORD_INDEX_BITS'(wrLocFull >> LANE_BITS);
    assign rdIndex = bram_pkg::WORD_INDEX_BITS'(rdLocFull >> LANE_BITS);
    assign wrOffset = bram_pkg::OFFSET_BITS'(
        32'(bram_pkg::OFFSET_BITS'(wrLocFull) & bram_pkg::OFFSET_BITS'(LANES - 1)) * DATA_WIDTH);
    assign rdOffset = bram_pkg::OFFSET_BITS'(
        32'(bram_pkg::OFFSET_BITS'(rdLocFull) & bram_pkg::OFFSET_BITS'(LANES - 1)) * DATA_WIDTH);

    // Data placed in its lane; mask pins only count in the wide arrangement
    logic [bram_pkg::WORD_BITS-1:0] wrWordAligned;
    logic [bram_pkg::WORD_BITS-1:0] laneEnable;
    logic [bram_pkg::WORD_BITS-1:0] wrBitEnable;
    assign wrWordAligned = bram_pkg::WORD_BITS'(32'(wrData_r) << wrOffset);
    assign laneEnable = bram_pkg::WORD_BITS'(((32'd1 << DATA_WIDTH) - 32'd1) << wrOffset);
    assign wrBitEnable = (DATA_WIDTH == bram_pkg::WIDTH_WIDE) ? ~wrMask_r : laneEnable;

    // Word seen by the read side
    logic [bram_pkg::WORD_BITS-1:0] rdWord;
    logic [DATA_WIDTH-1:0] rdLane;
    assign rdLane = DATA_WIDTH'(rdWord >> rdOffset);

    // Shared 4 kbit store
    bram_array #(
        .DATA_WIDTH(DATA_WIDTH),
        .INIT_IMAGE(INIT_IMAGE)
    ) uArray (
        .clock(clock),
        .writeGo(wrGo_r),
        .writeIndex(wrIndex),
        .writeWord(wrWordAligned),
        .writeBitEnable(wrBitEnable),
        .readIndex(rdIndex),
        .readWord(rdWord)
    );

    // Read word register; holds unless an enabled read completes
    logic [DATA_WIDTH-1:0] outWord_r;
    logic [DATA_WIDTH-1:0] outWord_nxt;
    assign outWord_nxt = rdGo_r ? rdLane : outWord_r;

    // Output register; write in the same cycle shows the old word
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            outWord_r <= DATA_WIDTH'(bram_pkg::RESET_WORD);
        end else begin
            outWord_r <= outWord_nxt;
        end
    end

    assign output_port_word = outWord_r;
endmodule : bram_top

`default_nettype wire

// >>> bench/bram_fab.sv
`timescale 1ns/1ps
`default_nettype none
// Fabric side of both ports: pins move on falling edges only
module bram_fab (
    input wire logic clock,
    output logic input_port_clock,
    output logic input_port_enable,
    output logic input_clock_gate,
    output logic [7:0] input_port_location,
    output logic [15:0] input_port_word,
    output logic [15:0] input_port_mask,
    output logic output_port_clock,
    output logic output_port_enable,
    output logic output_clock_gate,
    output logic [7:0] output_port_location
);
    // Idle low, so reset release shows no false edge
    initial begin
        {input_port_clock, input_port_enable, input_clock_gate, input_port_location} = 11'h0;
        {output_port_clock, output_port_enable, output_clock_gate, output_port_location} = 11'h0;
        {input_port_word, input_port_mask} = 32'h0;
    end
    // One port clock pulse, four cycles each phase
    task automatic op(input bit rd, input bit en, input bit gt, input logic [7:0] loc,
            input logic [15:0] dat, input logic [15:0] msk);
        @(negedge clock);
        if (rd) begin
            {output_port_enable, output_clock_gate, output_port_location} = {en, gt, loc};
        end else begin
            {input_port_enable, input_clock_gate, input_port_location} = {en, gt, loc};
            {input_port_word, input_port_mask} = {dat, msk};
        end
        repeat (4) @(negedge clock);
        output_port_clock = rd;
        input_port_clock = !rd;
        repeat (4) @(negedge clock);
        {output_port_clock, input_port_clock} = 2'h0;
        // Enables and gates of both ports idle low between pulses
        {output_port_enable, output_clock_gate, input_port_enable, input_clock_gate} = 4'h0;
        // Released word and location lines turn over rather than hold a stale value
        {input_port_word, input_port_location} = ~{input_port_word, input_port_location};
        output_port_location = ~output_port_location;
    endtask : op
endmodule : bram_fab
`default_nettype wire

// >>> bench/bram_top_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks against a shadow of the store
module bram_top_props #(
    parameter int DATA_WIDTH = 16,
    parameter int ADDR_WIDTH = 8,
    parameter logic [bram_pkg::TOTAL_BITS-1:0] INIT_IMAGE = '0
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic input_port_clock,
    input wire logic input_port_enable,
    input wire logic input_clock_gate,
    input wire logic [ADDR_WIDTH-1:0] input_port_location,
    input wire logic [DATA_WIDTH-1:0] input_port_word,
    input wire logic [bram_pkg::WORD_BITS-1:0] input_port_mask,
    input wire logic output_port_clock,
    input wire logic output_port_enable,
    input wire logic output_clock_gate,
    input wire logic [ADDR_WIDTH-1:0] output_port_location,
    input wire logic [DATA_WIDTH-1:0] output_port_word
);
    logic wPin_r, rPin_r, seenRd_r;  // Pin levels last cycle, any read yet
    logic [3:0] rdAge_r;  // Cycles since enabled read, saturating
    logic [DATA_WIDTH-1:0] rdExp_r;  // Word due from last read
    logic [DATA_WIDTH-1:0] shadow [2**ADDR_WIDTH];
    wire logic wrGo = input_port_clock & ~wPin_r & input_port_enable & input_clock_gate;
    wire logic rdEdge = output_port_clock & ~rPin_r;
    wire logic rdGo = rdEdge & output_port_enable & output_clock_gate;
    // Mask exists only in the wide arrangement
    wire logic [DATA_WIDTH-1:0] keep = (DATA_WIDTH == 16) ? input_port_mask[DATA_WIDTH-1:0] : '0;
    // Preload; location 0 is never read before a write
    initial begin
        for (int i = 0; i < 2**ADDR_WIDTH; i++) shadow[i] = INIT_IMAGE[i*DATA_WIDTH +: DATA_WIDTH];
    end
    // Same-edge read still sees the old word
    always @(posedge clock) begin
        if (arst_n && wrGo) shadow[input_port_location] <= (shadow[input_port_location] & keep)
            | (input_port_word & ~keep);
        if (rdGo) rdExp_r <= shadow[output_port_location];
    end
    // Edge finder and read age
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {wPin_r, rPin_r, seenRd_r, rdAge_r} <= 7'h0f;
        end else begin
            {wPin_r, rPin_r} <= {input_port_clock, output_port_clock};
            seenRd_r <= seenRd_r | rdGo;
            rdAge_r <= rdGo ? 4'h0 : rdAge_r + {3'h0, rdAge_r != 4'hf};
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    a_reset_zero: assert property ($rose(arst_n) |-> output_port_word == '0)
        else $error("read word not cleared");
    a_hold_till_read: assert property (!seenRd_r |-> output_port_word == '0)
        else $error("read word moved before any read");
    a_change_cause: assert property ($changed(output_port_word) |-> rdAge_r inside {[2:6]})
        else $error("read word moved without a read");
    a_read_value: assert property (rdAge_r == 4'h7 |-> output_port_word == rdExp_r)
        else $error("read word wrong");
    a_gate_hold: assert property (rdEdge && !output_clock_gate && rdAge_r > 4'h6
        |=> $stable(output_port_word)[*6]) else $error("gated read moved word");
    a_enable_hold: assert property (rdEdge && !output_port_enable && rdAge_r > 4'h6
        |=> $stable(output_port_word)[*6]) else $error("disabled read moved word");
    a_write_quiet: assert property (wrGo && rdAge_r > 4'h6 |=> $stable(output_port_word)[*6])
        else $error("write moved read word");
    a_idle_stable: assert property (rdAge_r == 4'hf |-> $stable(output_port_word))
        else $error("idle read word moved");
endmodule : bram_top_props
bind bram_top bram_top_props #(.DATA_WIDTH(DATA_WIDTH), .ADDR_WIDTH(ADDR_WIDTH),
    .INIT_IMAGE(INIT_IMAGE)) props (.clock, .arst_n, .input_port_clock, .input_port_enable,
    .input_clock_gate, .input_port_location, .input_port_word, .input_port_mask,
    .output_port_clock, .output_port_enable, .output_clock_gate, .output_port_location,
    .output_port_word);
`default_nettype wire

// >>> bench/test_block_ram_4kbit_pseudo_dual_port.sv
`timescale 1ns/1ps
`default_nettype none
// Driver queues expected words, a watcher checks each read
module test_block_ram_4kbit_pseudo_dual_port;
    localparam logic [bram_pkg::TOTAL_BITS-1:0] IMG = {128{32'h3c5a_96e1}};  // Preload
    logic clock;
    logic arst_n = 1'b0;
    logic input_port_clock, input_port_enable, input_clock_gate;
    logic output_port_clock, output_port_enable, output_clock_gate;
    logic [7:0] input_port_location, output_port_location;
    logic [15:0] input_port_word, input_port_mask, output_port_word;
    logic [15:0] model [256];  // Expected store
    logic [15:0] notes [$];  // Words due, oldest first
    logic [15:0] lastOut = 16'h0000;  // Read word after reset
    logic [31:0] seed = 32'd34;
    int errTotal = 0;
    int testsRun = 0;
    int cyc = 0;
    bram_top #(.INIT_IMAGE(IMG)) dut (.clock, .arst_n, .input_port_clock, .input_port_enable,
        .input_clock_gate, .input_port_location, .input_port_word, .input_port_mask,
        .output_port_clock, .output_port_enable, .output_clock_gate, .output_port_location,
        .output_port_word);
    bram_fab fab (.clock, .input_port_clock, .input_port_enable, .input_clock_gate,
        .input_port_location, .input_port_word, .input_port_mask, .output_port_clock,
        .output_port_enable, .output_clock_gate, .output_port_location);
    // 100 MHz system clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic give_verdict();
        if (errTotal == 0 && testsRun > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // Write, keeping the model in step; refused when a control is low
    task automatic wr(input bit en, input bit gt, input logic [7:0] loc,
            input logic [15:0] dat, input logic [15:0] msk);
        if (en && gt) model[loc] = (model[loc] & msk) | (dat & ~msk);
        fab.op(1'b0, en, gt, loc, dat, msk);
    endtask : wr
    // Read; a refused one leaves the word as it was
    task automatic rd(input bit en, input bit gt, input logic [7:0] loc);
        if (en && gt) lastOut = model[loc];
        notes.push_back(lastOut);
        fab.op(1'b1, en, gt, loc, 16'h0000, 16'h0000);
    endtask : rd
    // Result settles well inside six cycles of the pin edge
    always @(posedge output_port_clock) begin
        repeat (6) @(negedge clock);
        testsRun = testsRun + 1;
        if (output_port_word !== notes[0]) begin
            errTotal = errTotal + 1;
            $display("Error at %0t: got %h expected %h", $time, output_port_word, notes[0]);
        end
        void'(notes.pop_front());
    end
    // Hang guard, far beyond the planned run
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            errTotal = errTotal + 1;
            give_verdict();
        end
    end
    initial begin
        for (int i = 0; i < 256; i++) model[i] = IMG[i*16 +: 16];
        repeat (10) @(posedge clock);
        @(negedge clock);
        arst_n = 1'b1;
        rd(1'b1, 1'b0, 8'h05);
        rd(1'b0, 1'b1, 8'h05);
        rd(1'b1, 1'b1, 8'h01);
        rd(1'b1, 1'b1, 8'hff);
        // Random words at every 17th location, read back in reverse
        for (int i = 0; i < 16; i++) wr(1'b1, 1'b1, 8'(i * 17), 16'(xs()), 16'h0000);
        for (int i = 15; i >= 0; i--) rd(1'b1, 1'b1, 8'(i * 17));
        wr(1'b0, 1'b1, 8'h11, 16'(xs()), 16'h0000);
        wr(1'b1, 1'b0, 8'h11, 16'(xs()), 16'h0000);
        rd(1'b1, 1'b1, 8'h11);
        // Random masks keep the bits marked one
        for (int i = 0; i < 4; i++) begin
            wr(1'b1, 1'b1, 8'h22, 16'(xs()), 16'(xs()));
            rd(1'b1, 1'b1, 8'h22);
        end
        repeat (10) @(negedge clock);
        give_verdict();
    end
endmodule : test_block_ram_4kbit_pseudo_dual_port
`default_nettype wire
